// File: core/fbp_params.svh
/*
  Constants of the block-protect logic: register offsets, field positions,
  reset values and address layout. Assumes a byte-addressed Avalon slave
  with one aligned 32-bit word per register.
*/
`ifndef FBP_PARAMS_SVH
`define FBP_PARAMS_SVH

// Register byte offsets
`define FBP_OFS_CTRL     5'h00
`define FBP_OFS_PROTECT  5'h04
`define FBP_OFS_ADDR     5'h08
`define FBP_OFS_DATA     5'h0C
`define FBP_OFS_STATUS   5'h10

// Control fields
`define FBP_CTRL_PGM     0
`define FBP_CTRL_ERASE   1
`define FBP_CTRL_MASS    2
`define FBP_CTRL_HV      3

// Status fields
`define FBP_ST_VTST      0
`define FBP_ST_BULK_OK   1
`define FBP_ST_ADDR_PROT 2
`define FBP_ST_ARMED     3
`define FBP_ST_LATCHED   4
`define FBP_ST_START_LSB 16

// Address layout
`define FBP_TOP_BITS     2'h3
`define FBP_PAGE_BITS    6
`define FBP_ROW_BITS     5
`define FBP_ALL_ONES     8'hFF
`define FBP_ALL_ZERO     8'h00
`define FBP_PROT_ADDR    16'hFFBE

// Reset values
`define FBP_RST_PROT     8'h00
`define FBP_RST_ADDR     16'h0000
`define FBP_RST_RDATA    32'h0000_0000

`endif

// File: core/fbp_pkg.sv
/*
  Types and decode functions of the block-protect logic.
  Assumes fbp_params.svh is on the include path.
*/
`include "fbp_params.svh"

package fbp_pkg;

  typedef enum logic [2:0] {
    FBP_IDLE    = 3'b000,
    FBP_SEL     = 3'b001,
    FBP_ARMED   = 3'b010,
    FBP_LATCHED = 3'b011,
    FBP_HV      = 3'b100
  } fbp_seq_t;

  // Start of protected range: top bits ones, low page bits zero
  function automatic logic [15:0] fbp_start(input logic [7:0] bits);
    fbp_start = {`FBP_TOP_BITS, bits, 6'h00};
  endfunction

  // True when a program (or, with page set, a page erase) is refused
  function automatic logic fbp_refused(input logic [7:0]  bits,
                                       input logic [15:0] addr,
                                       input logic [15:0] paddr,
                                       input logic        vtst,
                                       input logic        page);
    logic hit_pb;
    hit_pb = page ? (addr[15:6] == paddr[15:6]) : (addr == paddr);
    if (vtst)
      fbp_refused = 1'b0;
    else if (hit_pb)
      fbp_refused = 1'b1;
    else if (bits == `FBP_ALL_ONES)
      fbp_refused = 1'b0;
    else if (bits == `FBP_ALL_ZERO)
      fbp_refused = 1'b1;
    else
      fbp_refused = (addr >= fbp_start(bits));
  endfunction

  // Byte-lane merge of a bus write into a register word
  function automatic logic [31:0] fbp_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    fbp_merge = (old & ~m) | (wd & m);
  endfunction

endpackage

// File: core/fbp_sync.sv
/*
  Two-flop synchroniser for level inputs coming from pins.
  Assumes the input is a slow level; no pulse is guaranteed to pass.
*/
`timescale 1ns/1ps

module fbp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys, // System clock
  input  wire logic             rst,     // Async reset, active high
  input  wire logic [WIDTH-1:0] din,     // Asynchronous level
  output logic      [WIDTH-1:0] dout     // Synchronised level
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// File: core/fbp_range.sv
/*
  Protected-range decoder: start address, bulk-erase permission and two
  independent refusal checks. Purely combinational; assumes the protect
  byte is already registered on the system clock.
*/
`timescale 1ns/1ps

module fbp_range
  import fbp_pkg::*;
#(
  parameter logic [15:0] PROT_ADDR = `FBP_PROT_ADDR
) (
  input  wire logic [7:0]  bits,    // Protect-start bits
  input  wire logic        vtst,    // Test voltage sensed
  input  wire logic [15:0] addr_a,  // First address, byte check
  input  wire logic [15:0] addr_b,  // Second address
  input  wire logic        page_b,  // Second check is a page erase
  output logic      [15:0] start,   // Protect start address
  output logic             refuse_a,// First address refused
  output logic             refuse_b,// Second address refused
  output logic             bulk_ok  // Whole-array erase allowed
);

  assign start    = fbp_start(bits);
  assign refuse_a = fbp_refused(bits, addr_a, PROT_ADDR, vtst, 1'b0);
  assign refuse_b = fbp_refused(bits, addr_b, PROT_ADDR, vtst, page_b);
  // Without test voltage, any protected block shuts off bulk erase
  assign bulk_ok  = (bits == `FBP_ALL_ONES) | vtst;

endmodule

// File: core/fbp_core.sv
/*
  Block-protect controller for the on-chip program array, with an
  Avalon-MM register slave. Holds the program/erase select bits, the
  high-voltage enable and the target latch, and drives the array macro.
  Assumes the array macro supplies the stored protect-start byte on the
  system clock and acts on the arr_* strobes; the test-voltage detector
  output arrives asynchronously from the interrupt pin.
*/
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

module fbp_core
  import fbp_pkg::*;
#(
  parameter logic [15:0] PROT_ADDR = `FBP_PROT_ADDR
) (
  input  wire logic        clk_sys,          // 200 MHz system clock
  input  wire logic        rst,              // Async reset, active high
  input  wire logic [4:0]  avs_address,      // Byte address
  input  wire logic        avs_read,         // Read request
  input  wire logic        avs_write,        // Write request
  input  wire logic [3:0]  avs_byteenable,   // Write byte lanes
  input  wire logic [31:0] avs_writedata,    // Write data
  output logic [31:0]      avs_readdata,     // Read data
  output logic             avs_waitrequest,  // Stall, active high
  input  wire logic [7:0]  protect_start_bits, // Stored protect byte
  input  wire logic        test_high_voltage,  // Pin detector, async
  output logic [15:0]      arr_addr,         // Array target address
  output logic [7:0]       arr_wdata,        // Array program data
  output logic             arr_prog,         // One-cycle byte program
  output logic             arr_hv,           // High voltage to array
  output logic             arr_erase,        // Page erase active
  output logic             arr_mass          // Bulk erase active
);

  //////////////////////////////////////////////////////////////////////////
  // Registers and state

  fbp_seq_t    state;
  fbp_seq_t    next_state;
  logic        program_select;
  logic        erase_select;
  logic        mass_select;
  logic        high_voltage_enable;
  logic [15:0] addr_reg;
  logic [15:0] target;
  logic [7:0]  protect_start_byte;
  logic        vtst_s;

  //////////////////////////////////////////////////////////////////////////
  // Test-voltage pin and range decoding

  fbp_sync #(
    .WIDTH (1)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (test_high_voltage),
    .dout    (vtst_s)
  );

  wire logic [15:0] prot_start;
  wire logic        addr_refused;
  wire logic        tgt_refused;
  wire logic        bulk_ok;
  wire logic        page_op = erase_select & ~mass_select;

  fbp_range #(
    .PROT_ADDR (PROT_ADDR)
  ) u_range (
    .bits     (protect_start_byte),
    .vtst     (vtst_s),
    .addr_a   (addr_reg),
    .addr_b   (target),
    .page_b   (page_op),
    .start    (prot_start),
    .refuse_a (addr_refused),
    .refuse_b (tgt_refused),
    .bulk_ok  (bulk_ok)
  );

  // Stored byte only follows the array; no bus path reaches it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      protect_start_byte <= `FBP_RST_PROT;
    else
      protect_start_byte <= protect_start_bits;
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire logic        req     = avs_read | avs_write;
  wire logic        wr_fire = avs_write & ~avs_waitrequest;
  wire logic        rd_fire = avs_read & ~avs_waitrequest;
  wire logic        sel_ctrl   = (avs_address == `FBP_OFS_CTRL);
  wire logic        sel_prot   = (avs_address == `FBP_OFS_PROTECT);
  wire logic        sel_addr   = (avs_address == `FBP_OFS_ADDR);
  wire logic        sel_data   = (avs_address == `FBP_OFS_DATA);
  wire logic        sel_status = (avs_address == `FBP_OFS_STATUS);
  wire logic        wr_ctrl = wr_fire & sel_ctrl;
  wire logic        wr_addr = wr_fire & sel_addr;
  wire logic        wr_data = wr_fire & sel_data & avs_byteenable[0];
  wire logic        rd_prot = rd_fire & sel_prot;

  wire logic [31:0] ctrl_word = {28'h0, high_voltage_enable, mass_select,
                                 erase_select, program_select};
  wire logic [31:0] ctrl_new  = fbp_merge(ctrl_word, avs_writedata,
                                          avs_byteenable);
  wire logic [31:0] addr_new  = fbp_merge({16'h0, addr_reg},
                                          avs_writedata, avs_byteenable);

  wire logic        armed   = (state == FBP_ARMED) |
                              (state == FBP_LATCHED);
  wire logic        latched = (state == FBP_LATCHED) | (state == FBP_HV);

  wire logic [31:0] status_word = {
    prot_start, 11'h0, latched, armed, addr_refused, bulk_ok, vtst_s};

  wire logic [31:0] rd_mux =
    sel_ctrl   ? ctrl_word :
    sel_prot   ? {24'h0, protect_start_byte} :
    sel_addr   ? {16'h0, addr_reg} :
    sel_status ? status_word :
                 `FBP_RST_RDATA; // Data window and holes read zero

  //////////////////////////////////////////////////////////////////////////
  // Select interlock

  wire logic req_pgm  = ctrl_new[`FBP_CTRL_PGM];
  wire logic req_era  = ctrl_new[`FBP_CTRL_ERASE];
  wire logic req_mass = ctrl_new[`FBP_CTRL_MASS];
  wire logic req_hv   = ctrl_new[`FBP_CTRL_HV];
  // A write asking for both selects changes neither
  wire logic both_req = req_pgm & req_era;
  wire logic next_pgm = (wr_ctrl & ~both_req) ? req_pgm
                                              : program_select;
  wire logic next_era = (wr_ctrl & ~both_req) ? req_era
                                              : erase_select;
  // Mass select frozen while the pump runs
  wire logic next_mass = (wr_ctrl & ~high_voltage_enable) ? req_mass
                                                          : mass_select;

  //////////////////////////////////////////////////////////////////////////
  // High-voltage gate

  // Erase of the whole array needs an all-ones protect byte or test voltage; page and
  // program targets are checked against the latched address.
  wire logic target_ok = program_select ? ~tgt_refused :
                         mass_select    ? bulk_ok      :
                                          ~tgt_refused;
  wire logic hv_set_ok = (state == FBP_LATCHED) & target_ok &
                         (program_select ^ erase_select);
  wire logic hv_raise  = wr_ctrl & req_hv & ~high_voltage_enable &
                         hv_set_ok;
  // Refused raise just leaves the bit clear; no flag is kept
  wire logic next_hv   = hv_raise ? 1'b1 :
                         (wr_ctrl & ~req_hv) ? 1'b0 :
                         high_voltage_enable;

  //////////////////////////////////////////////////////////////////////////
  // Programming during high voltage

  // Byte program only within the latched row and outside protection
  wire logic same_row = (addr_reg[15:`FBP_ROW_BITS] ==
                         target[15:`FBP_ROW_BITS]);
  wire logic prog_go  = wr_data & (state == FBP_HV) &
                        program_select & high_voltage_enable &
                        same_row & ~addr_refused;

  // Page erase acts on the whole aligned page if selected when the target latched
  wire logic [15:0] page_base = {addr_reg[15:`FBP_PAGE_BITS],
                                 {`FBP_PAGE_BITS{1'b0}}};

  //////////////////////////////////////////////////////////////////////////
  // Sequence state machine

  always_comb begin
    next_state = state;
    case (state)
      FBP_IDLE: begin
        if (program_select | erase_select)
          next_state = FBP_SEL;
      end
      FBP_SEL: begin
        if (~(program_select | erase_select))
          next_state = FBP_IDLE;
        else if (rd_prot)
          next_state = FBP_ARMED;
      end
      FBP_ARMED: begin
        if (~(program_select | erase_select))
          next_state = FBP_IDLE;
        else if (wr_data)
          next_state = FBP_LATCHED;
      end
      FBP_LATCHED: begin
        if (~(program_select | erase_select))
          next_state = FBP_IDLE;
        else if (hv_raise)
          next_state = FBP_HV;
      end
      FBP_HV: begin
        // A new sequence needs a fresh protect read
        if (~high_voltage_enable)
          next_state = (program_select | erase_select) ? FBP_SEL
                                                       : FBP_IDLE;
      end
      default: next_state = FBP_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state               <= FBP_IDLE;
      program_select      <= 1'b0;
      erase_select        <= 1'b0;
      mass_select         <= 1'b0;
      high_voltage_enable <= 1'b0;
    end else begin
      state               <= next_state;
      program_select      <= next_pgm;
      erase_select        <= next_era;
      mass_select         <= next_mass;
      high_voltage_enable <= next_hv;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      addr_reg <= `FBP_RST_ADDR;
    else if (wr_addr)
      addr_reg <= addr_new[15:0];
  end

  // Target latch: the address written while armed or latched
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      target <= `FBP_RST_ADDR;
    else if (wr_data & armed)
      target <= addr_reg;
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait state per access

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `FBP_RST_RDATA;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (avs_read & avs_waitrequest)
        avs_readdata <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Array drive

  // Erase strobes drop as soon as the erase select is cleared, while the
  // pump stays on until software clears the enable.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arr_addr  <= `FBP_RST_ADDR;
      arr_wdata <= 8'h00;
      arr_prog  <= 1'b0;
      arr_hv    <= 1'b0;
      arr_erase <= 1'b0;
      arr_mass  <= 1'b0;
    end else begin
      arr_prog  <= prog_go;
      arr_hv    <= next_hv;
      arr_erase <= next_hv & next_era & ~mass_select;
      arr_mass  <= next_hv & next_era & mass_select & bulk_ok;
      if (prog_go) begin
        arr_addr  <= addr_reg;
        arr_wdata <= avs_writedata[7:0];
      end else if (wr_data & armed) begin
        arr_addr  <= page_op ? page_base : addr_reg;
      end
    end
  end

endmodule

// File: tb/fbp_core_sva.sv
/*
  Checker for the block-protect controller: bus answer timing, high-voltage
  gating against the protected range, and array strobe relations.
  Assumes it is bound to fbp_core and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "fbp_params.svh"

module fbp_core_sva #(
  parameter logic [15:0] PROT_ADDR = `FBP_PROT_ADDR
) (
  input wire logic        clk_sys,            // System clock
  input wire logic        rst,                // Async reset
  input wire logic [4:0]  avs_address,        // Byte address
  input wire logic        avs_read,           // Read request
  input wire logic        avs_write,          // Write request
  input wire logic [3:0]  avs_byteenable,     // Write lanes
  input wire logic [31:0] avs_writedata,      // Write data
  input wire logic [31:0] avs_readdata,       // Read data
  input wire logic        avs_waitrequest,    // Stall
  input wire logic [7:0]  protect_start_bits, // Stored protect byte
  input wire logic        test_high_voltage,  // Pin detector
  input wire logic [15:0] arr_addr,           // Array target
  input wire logic [7:0]  arr_wdata,          // Program data
  input wire logic        arr_prog,           // Byte program pulse
  input wire logic        arr_hv,             // High voltage
  input wire logic        arr_erase,          // Page erase
  input wire logic        arr_mass            // Bulk erase
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  sequence hv_rise_s;
    !arr_hv ##1 arr_hv;
  endsequence

  sequence req_rise_s;
    !(avs_read || avs_write) ##1 (avs_read || avs_write);
  endsequence

  ////////////////////////////////////////////////////////////////////////
  wait_answer_a: assert property (req_rise_s |=> !avs_waitrequest)
    else $error("waitrequest did not drop one cycle after request");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  hv_cause_a: assert property (hv_rise_s |->
    $past(avs_write && !avs_waitrequest && avs_address == `FBP_OFS_CTRL
          && avs_byteenable[0] && avs_writedata[`FBP_CTRL_HV]))
    else $error("high voltage rose without a control write");
  zero_lock_a: assert property (hv_rise_s |->
    protect_start_bits != 8'h00 || test_high_voltage)
    else $error("high voltage with all-zero protect byte");
  range_lock_a: assert property (hv_rise_s ##0 (!arr_mass &&
    !test_high_voltage && protect_start_bits != 8'hFF) |->
    arr_addr < {2'b11, protect_start_bits, 6'h00})
    else $error("high voltage on a protected target");
  byte_lock_a: assert property (hv_rise_s ##0 !test_high_voltage |->
    (arr_erase ? arr_addr[15:6] != PROT_ADDR[15:6]
               : (arr_mass || arr_addr != PROT_ADDR)))
    else $error("high voltage on the protect byte");
  mass_lock_a: assert property (arr_mass |->
    protect_start_bits == 8'hFF || test_high_voltage)
    else $error("bulk erase while a block is protected");
  sel_lock_a: assert property (arr_prog |-> !arr_erase && !arr_mass)
    else $error("program and erase active together");
  prog_cause_a: assert property (arr_prog |-> arr_hv ##1 !arr_prog
    and $past(avs_write && !avs_waitrequest &&
              avs_address == `FBP_OFS_DATA))
    else $error("program pulse without accepted data write");
  prog_range_a: assert property (arr_prog && !test_high_voltage |->
    arr_addr != PROT_ADDR && (protect_start_bits == 8'hFF ||
    (protect_start_bits != 8'h00 &&
     arr_addr < {2'b11, protect_start_bits, 6'h00})))
    else $error("program pulse inside protected range");
  page_align_a: assert property (arr_erase |-> arr_addr[5:0] == 6'h00)
    else $error("page erase target not page aligned");
endmodule

bind fbp_core fbp_core_sva #(.PROT_ADDR(PROT_ADDR)) fbp_core_sva_inst (
  .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .protect_start_bits(protect_start_bits),
  .test_high_voltage(test_high_voltage), .arr_addr(arr_addr),
  .arr_wdata(arr_wdata), .arr_prog(arr_prog), .arr_hv(arr_hv),
  .arr_erase(arr_erase), .arr_mass(arr_mass));

// File: tb/flash_block_protect_tb_top.sv
/*
  Self-checking bench for the block-protect controller: register access,
  then program and erase attempts against several protect bytes.
  Assumes fbp_core and its bound checker are compiled before it.
*/
`timescale 1ns/1ps
`include "fbp_params.svh"

module flash_block_protect_tb_top;
  localparam logic [15:0] PROT_ADDR = `FBP_PROT_ADDR;
  logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0]  protect_start_bits, arr_wdata;
  logic        test_high_voltage, arr_prog, arr_hv, arr_erase, arr_mass;
  logic [15:0] arr_addr;
  int          failures;
  int          total_checks;

  fbp_core fbp_core_inst (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .protect_start_bits(protect_start_bits),
    .test_high_voltage(test_high_voltage), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_prog(arr_prog), .arr_hv(arr_hv),
    .arr_erase(arr_erase), .arr_mass(arr_mass));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    check("bus answer", n, 32'h2);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] q;
    logic [7:0]  tbl [6] = '{8'h00, 8'hB8, 8'hBB, 8'hDE, 8'hFE, 8'hFF};
    bus(1'b0, 5'h14, 32'h0, q);
    check("unmapped", q, 32'h0);
    bus(1'b1, `FBP_OFS_CTRL, 32'h3, q);
    bus(1'b0, `FBP_OFS_CTRL, 32'h0, q);
    check("both selects", q, 32'h0);
    bus(1'b1, `FBP_OFS_ADDR, 32'h1234, q);
    avs_byteenable <= 4'h2;
    bus(1'b1, `FBP_OFS_ADDR, 32'h5600, q);
    avs_byteenable <= 4'hF;
    bus(1'b0, `FBP_OFS_ADDR, 32'h0, q);
    check("lane merge", q, 32'h5634);
    foreach (tbl[i]) begin
      protect_start_bits <= tbl[i];
      bus(1'b1, `FBP_OFS_PROTECT, 32'h11, q);
      bus(1'b0, `FBP_OFS_PROTECT, 32'h0, q);
      check("protect byte", q, {24'h0, tbl[i]});
      bus(1'b0, `FBP_OFS_STATUS, 32'h0, q);
      check("bulk allowed", q[1], tbl[i] == 8'hFF);
      if (tbl[i] != 8'h00 && tbl[i] != 8'hFF)
        check("start addr", q[31:16], {2'b11, tbl[i], 6'h00});
    end
  endtask

  // Select, optional protect read, latch, high-voltage sequence
  task automatic try_op(input logic [7:0] pb, input logic tv,
                        input logic [3:0] ctl, input logic [15:0] a,
                        input logic rd_prot, input logic exp_hv);
    logic [31:0] q;
    protect_start_bits <= pb;
    test_high_voltage <= tv;
    repeat (4) @(posedge clk_sys);
    bus(1'b1, `FBP_OFS_CTRL, {28'h0, ctl}, q);
    if (rd_prot)
      bus(1'b0, `FBP_OFS_PROTECT, 32'h0, q);
    bus(1'b0, `FBP_OFS_STATUS, 32'h0, q);
    check("armed", {q[3], q[0]}, {rd_prot, tv});
    bus(1'b1, `FBP_OFS_ADDR, {16'h0, a}, q);
    bus(1'b1, `FBP_OFS_DATA, 32'h5A, q);
    bus(1'b1, `FBP_OFS_CTRL, {28'h0, ctl | 4'h8}, q);
    @(posedge clk_sys);
    #1;
    check("high voltage", arr_hv, exp_hv);
    if (!exp_hv)
      check("array idle", {arr_prog, arr_erase, arr_mass}, 3'h0);
    else if (ctl == 4'h1) begin
      bus(1'b1, `FBP_OFS_DATA, 32'hC3, q);
      #1;
      check("prog pulse", {arr_prog, arr_wdata, arr_addr},
            {1'b1, 8'hC3, a});
    end
    else if (ctl == 4'h2)
      check("page erase", {arr_erase, arr_addr},
            {1'b1, a[15:6], 6'h00});
    else
      check("bulk erase", arr_mass, 1'b1);
    bus(1'b1, `FBP_OFS_CTRL, 32'h0, q);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0;
    protect_start_bits = 8'hFF;
    test_high_voltage = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    try_op(8'hFF, 1'b0, 4'h1, 16'h8000, 1'b1, 1'b1);
    try_op(8'hFF, 1'b0, 4'h1, 16'h8000, 1'b0, 1'b0);
    try_op(8'h00, 1'b0, 4'h1, 16'h0000, 1'b1, 1'b0);
    try_op(8'hFE, 1'b0, 4'h1, 16'hFF7F, 1'b1, 1'b1);
    try_op(8'hFE, 1'b0, 4'h1, 16'hFF80, 1'b1, 1'b0);
    try_op(8'hB9, 1'b0, 4'h2, 16'hEE3F, 1'b1, 1'b1);
    try_op(8'hB9, 1'b0, 4'h2, 16'hEE40, 1'b1, 1'b0);
    try_op(8'hFF, 1'b0, 4'h1, PROT_ADDR, 1'b1, 1'b0);
    try_op(8'hFF, 1'b0, 4'h2, 16'hFF80, 1'b1, 1'b0);
    try_op(8'hFF, 1'b1, 4'h1, PROT_ADDR, 1'b1, 1'b1);
    try_op(8'hFF, 1'b0, 4'h6, 16'h1234, 1'b1, 1'b1);
    try_op(8'hDE, 1'b0, 4'h6, 16'h1234, 1'b1, 1'b0);
    try_op(8'hDE, 1'b1, 4'h6, 16'h1234, 1'b1, 1'b1);
    try_op(8'hDE, 1'b0, 4'h2, 16'hFFC0, 1'b1, 1'b0);
    stop_test();
  end

  // Whole run is well under ten thousand cycles
  initial begin
    #50000;
    failures++;
    stop_test();
  end
endmodule
